// file: common/board_cfg_cfg.svh
// offsets, field positions, reset values and timing for the board configuration peripheral
`ifndef BOARD_CFG_CFG_SVH
`define BOARD_CFG_CFG_SVH
`define OFS_BOARD_IDENTIFIER      24'h000000
`define OFS_FIRMWARE_REVISION     24'h000004
`define OFS_FLASH_SERIAL_CONTROL  24'h000008
`define OFS_FLASH_SERIAL_STATUS   24'h00000c
`define OFS_CONFIG_PORT_CONTROL   24'h000010
`define OFS_CONFIG_PORT_WRITE     24'h000014
`define OFS_CONFIG_PORT_READ      24'h000018
`define OFS_CONFIG_PORT_STATUS    24'h00001c
`define GROUP_BASE                24'h000000
`define GROUP_MASK                24'hffffe0
`define FLASH_CONTROL_RESET       32'h00000080
`define CONFIG_WRITE_RESET        32'h00000000
`define BIT_CHIP_SELECT_HIGH      8
`define BIT_CHIP_SELECT_LOW       9
`define BIT_START                 10
`define BIT_DONE                  11
`define POS_MAJOR                 8
`define POS_BUILD_TYPE            16
`define POS_SLOT                  24
`define CLK_PERIOD_NS             5
`define SCK_PERIOD_NS             160
`define SCK_HALF_CYCLES           ((`SCK_PERIOD_NS / 2) / `CLK_PERIOD_NS)
`endif

// file: common/board_cfg_pkg.sv
// shared types for the board configuration peripheral
package board_cfg_pkg;
  typedef enum logic [3:0] {
    sel_none, sel_ident, sel_rev, sel_fctl, sel_fstat,
    sel_pctl, sel_pwr, sel_prd, sel_pstat
  } reg_sel_e;
  typedef enum logic {eng_idle, eng_shift} engine_state_e;
endpackage

// file: common/flash_serial_if.sv
// handshake between register logic and the flash shift engine
`timescale 1ns/1ps
interface flash_serial_if;
  logic       start;
  logic [7:0] tx_byte;
  logic [7:0] rx_byte;
  logic       done;
  modport ctrl   (output start, output tx_byte, input rx_byte, input done);
  modport engine (input start, input tx_byte, output rx_byte, output done);
endinterface // flash_serial_if

// file: design/flash_serial_engine.sv
// eight-bit mode zero shift engine for the serial flash
`timescale 1ns/1ps
`include "board_cfg_cfg.svh"
module flash_serial_engine
  import board_cfg_pkg::*;
#(
  parameter int HALF_CYCLES = `SCK_HALF_CYCLES
)(
  input  wire logic       clk,       // system clock
  input  wire logic       resetn,    // sync reset, active low
  flash_serial_if.engine  fs,        // start and byte handshake
  input  wire logic       flash_miso, // flash data out, async pin
  output logic            flash_sck, // serial clock
  output logic            flash_mosi // serial data to flash
);
  engine_state_e state, next_state;
  logic [7:0] shreg, next_shreg, rx, next_rx;
  logic [2:0] bit_cnt, next_bit_cnt;
  logic [7:0] div_cnt, next_div_cnt;
  logic       sck, next_sck, done, next_done;
  logic [7:0] rx_byte, next_rx_byte;
  logic       miso_meta, miso_s;
  logic       tick;

  ////////////////////////////////////////////////////////////////////////////
  // two-flop synchroniser; first stage feeds only the second
  always_ff @(posedge clk)
  begin
    miso_meta <= flash_miso;
    miso_s    <= miso_meta;
  end

  ////////////////////////////////////////////////////////////////////////////
  // half-period enable from the divider
  assign tick = (div_cnt == 8'(HALF_CYCLES - 1));

  // shift sequencing: sample on rising edge, shift on falling
  always_comb
  begin
    next_state   = state;
    next_shreg   = shreg;
    next_rx      = rx;
    next_bit_cnt = bit_cnt;
    next_div_cnt = (state == eng_shift && !tick) ? div_cnt + 8'h01 : 8'h00;
    next_sck     = sck;
    next_done    = done;
    next_rx_byte = rx_byte;
    case (state)
      eng_idle:
        if (fs.start)
        begin
          next_state   = eng_shift;
          next_shreg   = fs.tx_byte;
          next_bit_cnt = 3'h0;
          next_done    = 1'b0;
        end
      eng_shift:
        if (tick)
        begin
          if (!sck)
          begin
            next_sck = 1'b1;
            next_rx  = {rx[6:0], miso_s};
          end
          else
          begin
            next_sck = 1'b0;
            if (bit_cnt == 3'h7)
            begin
              next_state   = eng_idle;
              next_done    = 1'b1;
              next_rx_byte = rx;
            end
            else
            begin
              next_bit_cnt = bit_cnt + 3'h1;
              next_shreg   = {shreg[6:0], 1'b0};
            end
          end
        end
      default: next_state = eng_idle;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      state   <= eng_idle;
      shreg   <= 8'h00;
      rx      <= 8'h00;
      bit_cnt <= 3'h0;
      div_cnt <= 8'h00;
      sck     <= 1'b0;
      done    <= 1'b1;
      rx_byte <= 8'h00;
    end
    else
    begin
      state   <= next_state;
      shreg   <= next_shreg;
      rx      <= next_rx;
      bit_cnt <= next_bit_cnt;
      div_cnt <= next_div_cnt;
      sck     <= next_sck;
      done    <= next_done;
      rx_byte <= next_rx_byte;
    end
  end

  assign flash_sck  = sck;
  assign flash_mosi = shreg[7];
  assign fs.done    = done;
  assign fs.rx_byte = rx_byte;
endmodule // flash_serial_engine

// file: design/config_port_bridge.sv
// holding registers toward the internal configuration port
`timescale 1ns/1ps
`include "board_cfg_cfg.svh"
module config_port_bridge (
  input  wire logic        clk,         // system clock
  input  wire logic        resetn,      // sync reset, active low
  input  wire logic        wr_ctrl,     // host writes control
  input  wire logic        wr_data,     // host writes data
  input  wire logic        rd_data,     // host reads data
  input  wire logic [31:0] wdata,       // host write word
  input  wire logic [31:0] port_rdata,  // word from the port
  output logic      [31:0] port_ctrl,   // control word to the port
  output logic      [31:0] port_wdata,  // data word to the port
  output logic             port_wr,     // one-cycle write strobe
  output logic             port_rd,     // one-cycle read strobe
  output logic      [31:0] held_rdata   // last word from the port
);
  logic [31:0] next_ctrl, next_wdata, next_held;
  logic        next_wr, next_rd;

  ////////////////////////////////////////////////////////////////////////////
  // control reset to zero rather than left unknown, for a clean start
  always_comb
  begin
    next_ctrl  = wr_ctrl ? wdata : port_ctrl;
    next_wdata = wr_data ? wdata : port_wdata;
    next_wr    = wr_data;
    next_rd    = rd_data;
    next_held  = port_rdata;
  end

  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      port_ctrl  <= 32'h00000000;
      port_wdata <= `CONFIG_WRITE_RESET;
      port_wr    <= 1'b0;
      port_rd    <= 1'b0;
      held_rdata <= 32'h00000000;
    end
    else
    begin
      port_ctrl  <= next_ctrl;
      port_wdata <= next_wdata;
      port_wr    <= next_wr;
      port_rd    <= next_rd;
      held_rdata <= next_held;
    end
  end
endmodule // config_port_bridge

// file: design/board_config_flash_port.sv
// board configuration peripheral: identity, revision, flash serial port, config port
`timescale 1ns/1ps
`include "board_cfg_cfg.svh"
module board_config_flash_port
  import board_cfg_pkg::*;
#(
  parameter logic [31:0] IDENT_WORD     = 32'h42434650, // arbitrary value
  parameter logic [7:0]  MINOR_REVISION = 8'h00,        // firmware minor
  parameter logic [7:0]  MAJOR_REVISION = 8'h01,        // firmware major
  parameter logic [7:0]  BUILD_TYPE     = 8'h00,        // arbitrary value
  parameter int          SCK_HALF       = `SCK_HALF_CYCLES
)(
  input  wire logic        clk,               // system clock 200 MHz
  input  wire logic        resetn,            // sync reset, active low
  input  wire logic [23:0] bus_addr,          // A24 byte address
  input  wire logic        bus_wr,            // single-cycle write strobe
  input  wire logic        bus_rd,            // single-cycle read strobe
  input  wire logic [31:0] bus_wdata,         // write data
  output logic      [31:0] bus_rdata,         // read data
  output logic             bus_ack,           // access done, one cycle
  input  wire logic [4:0]  slot_pins,         // backplane slot strap
  output logic             flash_chip_select, // flash select line
  output logic             flash_sck,         // flash serial clock
  output logic             flash_mosi,        // data to flash
  input  wire logic        flash_miso,        // data from flash
  output logic      [31:0] port_ctrl,         // config port control
  output logic      [31:0] port_wdata,        // config port write word
  output logic             port_wr,           // config port write strobe
  output logic             port_rd,           // config port read strobe
  input  wire logic [31:0] port_rdata,        // config port read word
  input  wire logic [31:0] port_status        // config port status
);
  flash_serial_if fs ();

  logic [7:0]  tx_byte, next_tx_byte;
  logic        cs, next_cs;
  logic        start, next_start;
  logic [31:0] rdata, next_rdata;
  logic        ack, next_ack;
  logic [4:0]  slot_meta, slot_sync;
  logic [31:0] held_rdata;
  logic [31:0] revision_word;
  reg_sel_e    wsel, rsel;
  logic        wr_fctl, wr_pctl, wr_pwr, rd_prd;

  ////////////////////////////////////////////////////////////////////////////
  // address decode shared by the write and read paths
  function automatic reg_sel_e decode(input logic [23:0] a);
    reg_sel_e s;
    s = sel_none;
    if ((a & `GROUP_MASK) == `GROUP_BASE)
    begin
      case (a)
        `OFS_BOARD_IDENTIFIER:     s = sel_ident;
        `OFS_FIRMWARE_REVISION:    s = sel_rev;
        `OFS_FLASH_SERIAL_CONTROL: s = sel_fctl;
        `OFS_FLASH_SERIAL_STATUS:  s = sel_fstat;
        `OFS_CONFIG_PORT_CONTROL:  s = sel_pctl;
        `OFS_CONFIG_PORT_WRITE:    s = sel_pwr;
        `OFS_CONFIG_PORT_READ:     s = sel_prd;
        `OFS_CONFIG_PORT_STATUS:   s = sel_pstat;
        default:                   s = sel_none; // unaligned or unmapped
      endcase
    end
    return s;
  endfunction

  assign wsel    = decode(bus_addr);
  assign rsel    = wsel;
  assign wr_fctl = bus_wr && (wsel == sel_fctl);
  assign wr_pctl = bus_wr && (wsel == sel_pctl);
  assign wr_pwr  = bus_wr && (wsel == sel_pwr);
  assign rd_prd  = bus_rd && !bus_wr && (rsel == sel_prd);

  ////////////////////////////////////////////////////////////////////////////
  // slot strap comes from the backplane, so it is synchronised first
  always_ff @(posedge clk)
  begin
    slot_meta <= slot_pins;
    slot_sync <= slot_meta;
  end

  // revision word fields
  assign revision_word = {3'h0, slot_sync, BUILD_TYPE, MAJOR_REVISION,
                          MINOR_REVISION};

  ////////////////////////////////////////////////////////////////////////////
  // flash control: transmit byte, chip select and start pulse
  always_comb
  begin
    next_tx_byte = tx_byte;
    next_cs      = cs;
    next_start   = 1'b0;
    if (wr_fctl)
    begin
      next_tx_byte = bus_wdata[7:0];
      if (bus_wdata[`BIT_CHIP_SELECT_LOW])
        next_cs = 1'b0;
      // high wins when both bits are written, keeping the flash safe
      if (bus_wdata[`BIT_CHIP_SELECT_HIGH])
        next_cs = 1'b1;
      // a start while busy is dropped; software must poll first
      next_start = bus_wdata[`BIT_START] && fs.done;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      tx_byte <= 8'(`FLASH_CONTROL_RESET);
      cs      <= 1'b1;
      start   <= 1'b0;
    end
    else
    begin
      tx_byte <= next_tx_byte;
      cs      <= next_cs;
      start   <= next_start;
    end
  end

  assign fs.start          = start;
  assign fs.tx_byte        = tx_byte;
  assign flash_chip_select = cs;

  ////////////////////////////////////////////////////////////////////////////
  // read mux and single-cycle acknowledge; write-only bits read zero
  always_comb
  begin
    next_rdata = rdata;
    next_ack   = bus_wr || bus_rd;
    if (bus_rd && !bus_wr)
    begin
      case (rsel)
        sel_ident: next_rdata = IDENT_WORD;
        sel_rev:   next_rdata = revision_word;
        sel_fctl:  next_rdata = {24'h000000, tx_byte};
        // done also reads zero in the cycle a start is pending
        sel_fstat: next_rdata = {20'h00000, fs.done && !start,
                                 3'h0, fs.rx_byte};
        sel_pctl:  next_rdata = port_ctrl;
        sel_prd:   next_rdata = held_rdata;
        sel_pstat: next_rdata = port_status;
        default:   next_rdata = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      rdata <= 32'h00000000;
      ack   <= 1'b0;
    end
    else
    begin
      rdata <= next_rdata;
      ack   <= next_ack;
    end
  end

  assign bus_rdata = rdata;
  assign bus_ack   = ack;

  ////////////////////////////////////////////////////////////////////////////
  // shift engine and config port holding registers
  flash_serial_engine #(
    .HALF_CYCLES (SCK_HALF)
  ) u_engine (
    .clk        (clk),
    .resetn     (resetn),
    .fs         (fs.engine),
    .flash_miso (flash_miso),
    .flash_sck  (flash_sck),
    .flash_mosi (flash_mosi)
  );

  config_port_bridge u_bridge (
    .clk        (clk),
    .resetn     (resetn),
    .wr_ctrl    (wr_pctl),
    .wr_data    (wr_pwr),
    .rd_data    (rd_prd),
    .wdata      (bus_wdata),
    .port_rdata (port_rdata),
    .port_ctrl  (port_ctrl),
    .port_wdata (port_wdata),
    .port_wr    (port_wr),
    .port_rd    (port_rd),
    .held_rdata (held_rdata)
  );
endmodule // board_config_flash_port

// file: testbench/board_cfg_checker_assertions.sv
// concurrent checks on the board configuration peripheral ports
`timescale 1ns/1ps
module board_cfg_checker #(
  parameter logic [31:0] IDENT_WORD     = 32'h0, // identifier word
  parameter logic [7:0]  MINOR_REVISION = 8'h00, // firmware minor
  parameter logic [7:0]  MAJOR_REVISION = 8'h00, // firmware major
  parameter logic [7:0]  BUILD_TYPE     = 8'h00  // firmware variant
)(
  input wire logic        clk,               // system clock
  input wire logic        resetn,            // sync reset, active low
  input wire logic [23:0] bus_addr,          // access address
  input wire logic        bus_wr,            // write strobe
  input wire logic        bus_rd,            // read strobe
  input wire logic [31:0] bus_wdata,         // write data
  input wire logic [31:0] bus_rdata,         // read data
  input wire logic        bus_ack,           // access done
  input wire logic        flash_chip_select, // flash select line
  input wire logic        flash_sck,         // flash serial clock
  input wire logic        flash_mosi,        // data to flash
  input wire logic [31:0] port_wdata,        // config port write word
  input wire logic        port_wr,           // config port write strobe
  input wire logic        port_rd            // config port read strobe
);
  logic rd_only;
  logic ctl_wr;
  // decoded strobes; a write wins over a read in the same cycle
  assign rd_only = bus_rd && !bus_wr;
  assign ctl_wr  = bus_wr && bus_addr == 24'h000008;
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  ////////////////////////////////////////////////////////////////////////////////
  ack_follows_a: assert property ((bus_wr || bus_rd) |=> bus_ack)
    else $error("no ack after strobe");
  ack_lone_a: assert property (!(bus_wr || bus_rd) |=> !bus_ack)
    else $error("ack without strobe");
  ident_read_a: assert property (rd_only && bus_addr == 24'h0 |=> bus_rdata == IDENT_WORD)
    else $error("identifier word wrong");
  rev_read_a: assert property (rd_only && bus_addr == 24'h4 |=>
    bus_rdata[23:0] == {BUILD_TYPE, MAJOR_REVISION, MINOR_REVISION} && bus_rdata[31:29] == 3'h0)
    else $error("revision word wrong");
  cs_low_a: assert property (ctl_wr && bus_wdata[9] && !bus_wdata[8] |=> !flash_chip_select)
    else $error("select did not go low");
  cs_high_a: assert property (ctl_wr && bus_wdata[8] |=> flash_chip_select)
    else $error("select did not go high");
  cs_hold_a: assert property (!ctl_wr |=> $stable(flash_chip_select))
    else $error("select moved without a write");
  // mode zero: data may only move while the serial clock is low
  mosi_steady_a: assert property (flash_sck && $past(flash_sck) |-> $stable(flash_mosi))
    else $error("data moved while clock high");
  wdata_reset_a: assert property ($rose(resetn) |-> port_wdata == 32'h0)
    else $error("write word not cleared by reset");
  port_write_a: assert property (bus_wr && bus_addr == 24'h14 |=>
    port_wr && port_wdata == $past(bus_wdata))
    else $error("config port write not passed on");
  port_read_a: assert property (rd_only && bus_addr == 24'h18 |=> port_rd)
    else $error("config port read not passed on");
  cover property (ctl_wr && bus_wdata[10]);
  cover property ($rose(flash_sck));
  cover property (port_wr);
endmodule // board_cfg_checker

// file: testbench/flash_model.sv
// behavioural serial flash: echoes the inverse of each received byte
`timescale 1ns/1ps
module flash_model (
  input  wire logic       chip_select, // low selects the memory
  input  wire logic       sck,         // serial clock, mode zero
  input  wire logic       mosi,        // data into the memory
  input  wire logic [7:0] reply,       // first byte sent in a frame
  output logic            miso,        // data out of the memory
  output logic      [7:0] got          // last eight bits received
);
  logic [7:0] shreg;
  logic [2:0] cnt;
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    got = 8'h00;
    miso = 1'b0;
    shreg = 8'h00;
    cnt = 3'h0;
  end
  // a new frame starts with the reply byte, msb on the line at once
  always @(negedge chip_select)
  begin
    shreg = reply;
    cnt = 3'h0;
    miso = reply[7];
  end
  // released line shows the inverse, never the last value
  always @(posedge chip_select) miso = ~miso;
  // sample on the rising edge, msb first
  always @(posedge sck)
    if (!chip_select)
    begin
      got = {got[6:0], mosi};
      cnt = cnt + 3'h1;
    end
  // shift on the falling edge; after a full byte answer with its inverse
  always @(negedge sck)
    if (!chip_select)
    begin
      shreg = (cnt == 3'h0) ? ~got : {shreg[6:0], 1'b0};
      miso = shreg[7];
    end
endmodule // flash_model

// file: testbench/board_config_flash_port_tb_top.sv
// self-checking bench for the board configuration peripheral
`timescale 1ns/1ps
module board_config_flash_port_tb_top;
  localparam logic [31:0] IDW  = 32'h5a3c0f96; // arbitrary value
  localparam logic [7:0]  MINV = 8'h07;
  localparam logic [7:0]  MAJV = 8'h3c;
  localparam logic [7:0]  BTV  = 8'hff;        // top of the code range
  localparam logic [4:0]  SLOT = 5'h15;
  logic        clk, resetn, bus_wr, bus_rd, bus_ack, flash_chip_select;
  logic        flash_sck, flash_mosi, flash_miso, port_wr, port_rd;
  logic [23:0] bus_addr;
  logic [31:0] bus_wdata, bus_rdata, port_ctrl, port_wdata, port_rdata, port_status;
  logic [4:0]  slot_pins;
  logic [7:0]  got;
  int          n_mismatch, total_checks;
  ////////////////////////////////////////////////////////////////////////////////
  board_config_flash_port #(.IDENT_WORD(IDW), .MINOR_REVISION(MINV),
    .MAJOR_REVISION(MAJV), .BUILD_TYPE(BTV)) dut (
    .clk(clk), .resetn(resetn), .bus_addr(bus_addr), .bus_wr(bus_wr), .bus_rd(bus_rd),
    .bus_wdata(bus_wdata), .bus_rdata(bus_rdata), .bus_ack(bus_ack), .slot_pins(slot_pins),
    .flash_chip_select(flash_chip_select), .flash_sck(flash_sck), .flash_mosi(flash_mosi),
    .flash_miso(flash_miso), .port_ctrl(port_ctrl), .port_wdata(port_wdata),
    .port_wr(port_wr), .port_rd(port_rd), .port_rdata(port_rdata),
    .port_status(port_status));
  flash_model flash (.chip_select(flash_chip_select), .sck(flash_sck), .mosi(flash_mosi),
    .reply(8'hc3), .miso(flash_miso), .got(got));
  // 200 MHz system clock
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("unexpected at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask
  // one strobe cycle, then a bounded wait for the ack
  task automatic bus_access(input logic w, input logic [23:0] a, input logic [31:0] d,
                            output logic [31:0] q);
    int i;
    @(negedge clk);
    bus_addr = a;
    bus_wdata = d;
    bus_wr = w;
    bus_rd = !w;
    @(negedge clk);
    bus_wr = 1'b0;
    bus_rd = 1'b0;
    for (i = 0; i < 4 && bus_ack !== 1'b1; i++) @(negedge clk);
    if (bus_ack !== 1'b1)
    begin
      n_mismatch++;
      report_and_stop();
    end
    else
      q = bus_rdata;
  endtask
  task automatic wr(input logic [23:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus_access(1'b1, a, d, q);
  endtask
  task automatic rd_check(input logic [23:0] a, input logic [31:0] exp);
    logic [31:0] q;
    bus_access(1'b0, a, 32'h0, q);
    check(q, exp);
  endtask
  // one byte: start, a repeated start while busy, then poll completion
  task automatic xfer(input logic [7:0] tx, input logic [7:0] rx);
    logic [31:0] q;
    int i;
    wr(24'h8, {21'h0, 1'b1, 2'b00, tx});
    bus_access(1'b0, 24'hc, 32'h0, q);
    check({31'h0, q[11]}, 32'h0);
    // a second start while busy must be dropped
    wr(24'h8, {21'h0, 1'b1, 2'b00, tx});
    for (i = 0; i < 200 && q[11] !== 1'b1; i++) bus_access(1'b0, 24'hc, 32'h0, q);
    if (q[11] !== 1'b1)
    begin
      n_mismatch++;
      report_and_stop();
    end
    else
    begin
      check(q, {20'h0, 1'b1, 3'h0, rx});
      check({24'h0, got}, {24'h0, tx});
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    logic [31:0] rq;
    n_mismatch = 0;
    total_checks = 0;
    resetn = 1'b0;
    bus_wr = 1'b0;
    bus_rd = 1'b0;
    bus_addr = 24'h0;
    bus_wdata = 32'h0;
    slot_pins = SLOT;
    port_rdata = 32'h0f1e2d3c;
    port_status = 32'h00a5005a;
    // sixteen rising edges under reset, release off the sampling edge
    repeat (16) @(posedge clk);
    @(negedge clk);
    resetn = 1'b1;
    // reset values, identity and the read-only places
    rd_check(24'h0, IDW);
    rd_check(24'h4, {3'h0, SLOT, BTV, MAJV, MINV});
    rd_check(24'h8, 32'h00000080);
    rd_check(24'hc, 32'h00000800);
    check({31'h0, flash_chip_select}, 32'h1);
    check(port_wdata, 32'h0);
    wr(24'h0, 32'h0);
    rd_check(24'h0, IDW);
    rd_check(24'h20, 32'h0);
    rd_check(24'h6, 32'h0);
    $display("test registers done");
    // chip select and two bytes in one frame
    wr(24'h8, 32'h0000005c);
    rd_check(24'h8, 32'h0000005c);
    wr(24'h8, 32'h000002a5);
    check({31'h0, flash_chip_select}, 32'h0);
    xfer(8'ha5, 8'hc3);
    xfer(8'h13, 8'h5a);
    check({31'h0, flash_chip_select}, 32'h0);
    wr(24'h8, 32'h00000113);
    check({31'h0, flash_chip_select}, 32'h1);
    wr(24'h8, 32'h00000213);
    check({31'h0, flash_chip_select}, 32'h0);
    wr(24'h8, 32'h00000313);
    check({31'h0, flash_chip_select}, 32'h1);
    $display("test flash done");
    // configuration port pass-through; strobes are looked at while they stand
    wr(24'h10, 32'h1234abcd);
    rd_check(24'h10, 32'h1234abcd);
    check(port_ctrl, 32'h1234abcd);
    wr(24'h14, 32'hcafe0001);
    check({31'h0, port_wr}, 32'h1);
    check(port_wdata, 32'hcafe0001);
    rd_check(24'h14, 32'h0);
    bus_access(1'b0, 24'h18, 32'h0, rq);
    check({31'h0, port_rd}, 32'h1);
    check(rq, 32'h0f1e2d3c);
    rd_check(24'h1c, 32'h00a5005a);
    $display("test config port done");
    // reset in mid-run with the flash selected and the write word loaded
    wr(24'h8, 32'h00000200);
    resetn = 1'b0;
    repeat (16) @(posedge clk);
    @(negedge clk);
    resetn = 1'b1;
    check({31'h0, flash_chip_select}, 32'h1);
    check(port_wdata, 32'h0);
    rd_check(24'h8, 32'h00000080);
    rd_check(24'hc, 32'h00000800);
    $display("test mid-run reset done");
    report_and_stop();
  end
endmodule // board_config_flash_port_tb_top
bind board_config_flash_port board_cfg_checker #(.IDENT_WORD(IDENT_WORD),
  .MINOR_REVISION(MINOR_REVISION), .MAJOR_REVISION(MAJOR_REVISION),
  .BUILD_TYPE(BUILD_TYPE)) chk (.clk(clk), .resetn(resetn), .bus_addr(bus_addr),
  .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_wdata(bus_wdata), .bus_rdata(bus_rdata),
  .bus_ack(bus_ack), .flash_chip_select(flash_chip_select), .flash_sck(flash_sck),
  .flash_mosi(flash_mosi), .port_wdata(port_wdata), .port_wr(port_wr),
  .port_rd(port_rd));
